//--- hdl/adc_setup_pkg.sv
// shared constants, field layout and types of the converter setup word
package adc_setup_pkg;

  // ------------------------------------------------------------------
  // word widths
  // ------------------------------------------------------------------
  localparam int SETUP_W = 16;
  localparam int RESULT_W = 12;
  localparam int STREAM_W = 28;
  localparam logic [4:0] STREAM_BITS_READBACK = 5'h1c;
  localparam logic [4:0] STREAM_BITS_PLAIN = 5'h0c;
  localparam logic [4:0] LOAD_LAST_BIT = 5'h0f;
  localparam logic [4:0] COUNT_MAX = 5'h1f;

  // ------------------------------------------------------------------
  // field positions of the setup word
  // ------------------------------------------------------------------
  localparam int KEY_HI = 15;
  localparam int KEY_LO = 14;
  localparam int CHAN_HI = 13;
  localparam int CHAN_LO = 11;
  localparam int PWR_HI = 10;
  localparam int PWR_LO = 9;
  localparam int READBACK_BIT = 7;

  // ------------------------------------------------------------------
  // codes and reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] LOAD_KEY_ACCEPT = 2'h3;
  localparam logic [1:0] POLICY_AUTO_DOWN = 2'h0;
  localparam logic [1:0] POLICY_CONTINUOUS = 2'h1;
  localparam logic [2:0] CHANNEL_RESET = 3'h0;
  localparam logic [1:0] POLICY_RESET = POLICY_CONTINUOUS;
  localparam logic READBACK_RESET = 1'b0;
  localparam logic IDLE_LINE_LEVEL = 1'b1;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_TIME_NS = 3600;
  localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOWN_WAKE_NS = 150000;
  localparam int DOWN_WAKE_CYCLES = (DOWN_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_WAKE_NS = 1000;
  localparam int SLEEP_WAKE_CYCLES = (SLEEP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {CONV_IDLE, CONV_ACQUIRE, CONV_RUN} conv_state_e;
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_SLEEP, PWR_DOWN, PWR_WAKING} power_state_e;

  typedef struct packed {
    logic [2:0] channel;
    logic [1:0] policy;
    logic readback;
  } setup_fields_s;

  typedef struct packed {
    logic id;
    logic readback;
    logic [RESULT_W-1:0] result;
    logic [SETUP_W-1:0] setupWord;
  } snapshot_s;

  typedef struct packed {
    logic out;
    logic oeN;
  } line_pin_s;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic setup_fields_s decodeSetup(input logic [SETUP_W-1:0] w);
    setup_fields_s f;
    f.channel = w[CHAN_HI:CHAN_LO];
    f.policy = w[PWR_HI:PWR_LO];
    f.readback = w[READBACK_BIT];
    return f;
  endfunction

  function automatic logic [SETUP_W-1:0] encodeSetup(input setup_fields_s f);
    logic [SETUP_W-1:0] w;
    w = '0;
    w[CHAN_HI:CHAN_LO] = f.channel;
    w[PWR_HI:PWR_LO] = f.policy;
    w[READBACK_BIT] = f.readback;
    return w;
  endfunction

endpackage

//--- hdl/bit_sync.sv
// two-flop synchroniser for one level
`timescale 1ns/1ps
module bit_sync (
  input wire logic clk,
  input wire logic async,
  output logic synced
);

  typedef struct packed {
    logic meta;
    logic stable;
  } sync_state_s;

  sync_state_s q;
  sync_state_s d;

  always_comb begin
    d.meta = async;
    d.stable = q.meta;
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign synced = q.stable;

endmodule // bit_sync

//--- hdl/serial_link_shifter.sv
// serial-clock side: loads the setup word and shifts the result stream out
`timescale 1ns/1ps
module serial_link_shifter (
  input wire logic serialClock,
  input wire logic reset,
  input wire logic serialIn,
  input wire adc_setup_pkg::snapshot_s snap,
  output logic wordToggle,
  output logic [adc_setup_pkg::SETUP_W-1:0] heldWord,
  output logic outBit
);

  typedef struct packed {
    logic [4:0] count;
    logic [adc_setup_pkg::SETUP_W-1:0] shiftIn;
    logic [adc_setup_pkg::SETUP_W-1:0] held;
    logic toggle;
    logic anchorId;
  } link_state_s;

  link_state_s q;
  link_state_s d;
  logic resetLink;
  logic outQ;
  logic outD;
  // frame marker as last seen by the output flop; a mismatch means no bit of
  // the new frame has been driven yet, so the line waits at its idle level
  logic anchorOutQ;
  logic [adc_setup_pkg::STREAM_W-1:0] stream;
  logic [4:0] limit;
  logic [4:0] idx;

  bit_sync resetSync (.clk(serialClock), .async(reset), .synced(resetLink));

  // snap only changes at conversion end, when the host keeps the clock still
  always_comb begin
    logic fresh;
    logic [4:0] base;
    logic [adc_setup_pkg::SETUP_W-1:0] cur;
    fresh = 1'b0;
    base = '0;
    cur = '0;
    d = q;
    fresh = (snap.id != q.anchorId);
    base = fresh ? 5'h00 : q.count;
    cur = fresh ? '0 : q.shiftIn;
    d.anchorId = snap.id;
    d.shiftIn = {cur[adc_setup_pkg::SETUP_W-2:0], serialIn}; // see R7
    if (base != adc_setup_pkg::COUNT_MAX) begin
      d.count = base + 5'h01;
    end else begin
      d.count = base;
    end
    if (base == adc_setup_pkg::LOAD_LAST_BIT) begin
      d.held = {cur[adc_setup_pkg::SETUP_W-2:0], serialIn}; // see R7
      d.toggle = ~q.toggle;
    end
    if (resetLink) begin
      d = '0;
    end
  end

  // input sampled on the rising edge
  always_ff @(posedge serialClock) begin
    q <= d; // see R17
  end

  // ------------------------------------------------------------------
  // output stream: result then setup word when readback is on
  // ------------------------------------------------------------------
  always_comb begin
    stream = {snap.result, snap.setupWord}; // see R3
    limit = snap.readback ? adc_setup_pkg::STREAM_BITS_READBACK
                          : adc_setup_pkg::STREAM_BITS_PLAIN; // see R2
    idx = q.count - 5'h01;
    if (resetLink || q.count == 5'h00) begin
      outD = adc_setup_pkg::IDLE_LINE_LEVEL;
    end else if (idx < limit) begin
      outD = stream[5'(adc_setup_pkg::STREAM_W - 1) - idx];
    end else begin
      outD = 1'b0;
    end
  end

  // output changes on the falling edge so the host samples it on the rising one
  always_ff @(negedge serialClock) begin
    outQ <= outD; // see R17
    anchorOutQ <= q.anchorId;
  end

  assign wordToggle = q.toggle;
  assign heldWord = q.held;
  // new snapshot with no serial edge yet: show idle level before the first clock
  assign outBit = (snap.id != anchorOutQ) ? adc_setup_pkg::IDLE_LINE_LEVEL : outQ; // see R17

endmodule // serial_link_shifter

//--- hdl/adc_setup_core.sv
// converter setup word, conversion sequencing and readback of the result
//
// Operation
// R1 - readback carries channel of held result
// R2 - readback on: setup word follows result
// R3 - full readback is 28 clocks: 12+16
// R4 - output released while convert strobe high
// R5 - host finishes readback before conversion end
// R6 - conversion end overwrites result and readback
// R7 - setup word loaded msb first, 16 bits
// R8 - only load key 11 updates setup
// R9 - new setup applies after current conversion
// R10 - low-power idle needs a recovery interval
// R11 - bits 13:11 pick channel zero..seven
// R12 - codes 100..111 single-ended only
// R13 - power field 00: auto power down
// R14 - power field 01: always powered, default
// R15 - power upper bit set: auto sleep
// R16 - bit 7 enables readback, default off
// R17 - sample on rising, drive on falling
// R18 - output shows previous conversion's data
// R19 - unused bits ignored, read back zero
`timescale 1ns/1ps
module adc_setup_core #(
  parameter int DOWN_WAKE_CYCLES = adc_setup_pkg::DOWN_WAKE_CYCLES
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic serialClock,
  input wire logic serial_in_line,
  input wire logic convert_strobe,
  input wire logic [adc_setup_pkg::RESULT_W-1:0] sampleData,
  output adc_setup_pkg::line_pin_s serial_out_line,
  output logic [2:0] channel_select,
  output adc_setup_pkg::power_state_e powerState,
  output logic converterReady,
  output logic sampleHold
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    adc_setup_pkg::conv_state_e conv;
    adc_setup_pkg::power_state_e power;
    logic [15:0] convTimer;
    logic [15:0] wakeTimer;
    logic strobeSeen;
    logic toggleSeen;
    logic [adc_setup_pkg::SETUP_W-1:0] pendingWord;
    logic pendingValid;
    adc_setup_pkg::setup_fields_s active;
    adc_setup_pkg::snapshot_s snap;
    logic lineOeN;
    logic ready;
    logic hold;
  } core_state_s;

  localparam logic [15:0] CONV_LOAD = 16'(adc_setup_pkg::CONV_CYCLES - 1);
  localparam logic [15:0] DOWN_WAKE_LOAD = 16'(DOWN_WAKE_CYCLES);
  localparam logic [15:0] SLEEP_WAKE_LOAD = 16'(adc_setup_pkg::SLEEP_WAKE_CYCLES);

  core_state_s q;
  core_state_s d;

  logic strobeSync;
  logic toggleSync;
  logic wordToggle;
  logic [adc_setup_pkg::SETUP_W-1:0] heldWord;
  logic linkBit;

  // ------------------------------------------------------------------
  // crossings
  // ------------------------------------------------------------------
  // the strobe is a pin; the word event is a toggle whose data is held
  // stable for at least sixteen serial clocks after it flips
  bit_sync strobeSyncInst (
    .clk(mclk),
    .async(convert_strobe),
    .synced(strobeSync)
  );

  bit_sync toggleSyncInst (
    .clk(mclk),
    .async(wordToggle),
    .synced(toggleSync)
  );

  // ------------------------------------------------------------------
  // serial side
  // ------------------------------------------------------------------
  serial_link_shifter link (
    .serialClock(serialClock),
    .reset(reset),
    .serialIn(serial_in_line),
    .snap(q.snap),
    .wordToggle(wordToggle),
    .heldWord(heldWord),
    .outBit(linkBit)
  );

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // idle state that a policy asks for once a conversion ends
  function automatic adc_setup_pkg::power_state_e idleFor(input logic [1:0] policy);
    adc_setup_pkg::power_state_e s;
    if (policy[1]) begin
      s = adc_setup_pkg::PWR_SLEEP; // see R15
    end else if (policy == adc_setup_pkg::POLICY_AUTO_DOWN) begin
      s = adc_setup_pkg::PWR_DOWN; // see R13
    end else begin
      s = adc_setup_pkg::PWR_ACTIVE; // see R14
    end
    return s;
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic strobeRise;
    logic strobeFall;
    logic wordEvent;
    strobeRise = 1'b0;
    strobeFall = 1'b0;
    wordEvent = 1'b0;
    d = q;

    strobeRise = strobeSync & ~q.strobeSeen;
    strobeFall = ~strobeSync & q.strobeSeen;
    wordEvent = toggleSync ^ q.toggleSeen;
    d.strobeSeen = strobeSync;
    d.toggleSeen = toggleSync;

    // line is released for as long as the strobe is high
    d.lineOeN = strobeSync; // see R4

    // recovery from a low-power idle
    if (q.power == adc_setup_pkg::PWR_WAKING) begin
      if (q.wakeTimer == 16'h0000) begin
        d.power = adc_setup_pkg::PWR_ACTIVE; // see R10
      end else begin
        d.wakeTimer = q.wakeTimer - 16'h0001;
      end
    end

    case (q.conv)
      adc_setup_pkg::CONV_IDLE: begin
        if (strobeFall) begin
          d.conv = adc_setup_pkg::CONV_ACQUIRE;
          if (q.power == adc_setup_pkg::PWR_SLEEP) begin
            d.power = adc_setup_pkg::PWR_WAKING; // see R10
            d.wakeTimer = SLEEP_WAKE_LOAD;
          end else if (q.power == adc_setup_pkg::PWR_DOWN) begin
            d.power = adc_setup_pkg::PWR_WAKING; // see R10
            d.wakeTimer = DOWN_WAKE_LOAD;
          end
        end
      end
      adc_setup_pkg::CONV_ACQUIRE: begin
        if (strobeRise) begin
          d.conv = adc_setup_pkg::CONV_RUN;
          d.convTimer = CONV_LOAD;
          d.hold = 1'b1;
        end
      end
      adc_setup_pkg::CONV_RUN: begin
        if (q.convTimer != 16'h0000) begin
          d.convTimer = q.convTimer - 16'h0001;
        end else begin
          d.conv = adc_setup_pkg::CONV_IDLE;
          d.hold = 1'b0;
          // unread data of the previous conversion is lost here
          d.snap.result = sampleData; // see R6
          d.snap.setupWord = adc_setup_pkg::encodeSetup(q.active); // see R1, R19
          d.snap.readback = q.active.readback; // see R16
          d.snap.id = ~q.snap.id; // see R6, R18
          if (q.pendingValid) begin
            d.active = adc_setup_pkg::decodeSetup(q.pendingWord); // see R9, R11
            d.pendingValid = 1'b0;
            d.power = idleFor(q.pendingWord[adc_setup_pkg::PWR_HI:adc_setup_pkg::PWR_LO]);
          end else begin
            d.power = idleFor(q.active.policy);
          end
        end
      end
      default: begin
        d.conv = adc_setup_pkg::CONV_IDLE;
      end
    endcase

    // a word landing in the cycle that consumes the previous one still counts
    if (wordEvent) begin
      if (heldWord[adc_setup_pkg::KEY_HI:adc_setup_pkg::KEY_LO]
          == adc_setup_pkg::LOAD_KEY_ACCEPT) begin
        d.pendingWord = heldWord; // see R8
        d.pendingValid = 1'b1;
      end
    end

    d.ready = (d.power == adc_setup_pkg::PWR_ACTIVE);

    if (reset) begin
      d = '0;
      d.conv = adc_setup_pkg::CONV_IDLE;
      d.power = adc_setup_pkg::PWR_ACTIVE;
      d.active.channel = adc_setup_pkg::CHANNEL_RESET;
      d.active.policy = adc_setup_pkg::POLICY_RESET; // see R14
      d.active.readback = adc_setup_pkg::READBACK_RESET; // see R16
      d.snap.setupWord = adc_setup_pkg::encodeSetup(d.active);
      d.lineOeN = 1'b1;
      d.ready = 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    q <= d;
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // channel decode stays binary; which codes are wired is up to the mux
  assign channel_select = q.active.channel; // see R11, R12
  assign powerState = q.power;
  assign converterReady = q.ready;
  assign sampleHold = q.hold;
  assign serial_out_line.out = linkBit;
  assign serial_out_line.oeN = q.lineOeN;

endmodule // adc_setup_core

//--- verification/adc_setup_monitor.sv
// assertion checker bound to the converter setup core ports
`timescale 1ns/1ps
module adc_setup_monitor #(
  parameter int DOWN_WAKE_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic serialClock,
  input wire logic serial_in_line,
  input wire logic convert_strobe,
  input wire logic [adc_setup_pkg::RESULT_W-1:0] sampleData,
  input wire adc_setup_pkg::line_pin_s serial_out_line,
  input wire logic [2:0] channel_select,
  input wire adc_setup_pkg::power_state_e powerState,
  input wire logic converterReady,
  input wire logic sampleHold
);
  // --------------------------------------------------------------
  // helper logic
  // --------------------------------------------------------------
  // the shorter of the two wake times bounds every recovery
  localparam int WAKE_MIN = (DOWN_WAKE_CYCLES < 100) ? DOWN_WAKE_CYCLES : 100;
  logic [15:0] lowCnt_q;
  always_ff @(posedge mclk) begin
    if (reset || converterReady) begin
      lowCnt_q <= 16'h0;
    end else if (lowCnt_q != 16'hffff) begin
      lowCnt_q <= lowCnt_q + 16'h1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence convEnd;
    !sampleHold && ($past(sampleHold) || $past(sampleHold, 2));
  endsequence
  sequence convStart;
    $rose(convert_strobe);
  endsequence

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_release_strobe_high: assert property (convert_strobe [*4] |-> serial_out_line.oeN)
    else $error("output driven while strobe high");
  a_drive_strobe_low: assert property (!convert_strobe [*4] |-> !serial_out_line.oeN)
    else $error("output not driven while strobe low");
  a_out_on_fall: assert property ($changed(serial_out_line.out) |-> !serialClock)
    else $error("output moved while serial clock high");
  a_channel_at_end: assert property ($changed(channel_select) |-> convEnd)
    else $error("channel changed outside conversion end");
  a_channel_mid_conv: assert property (sampleHold |-> $stable(channel_select))
    else $error("channel changed during conversion");
  a_idle_at_end: assert property ($changed(powerState) && (powerState == adc_setup_pkg::PWR_SLEEP
    || powerState == adc_setup_pkg::PWR_DOWN) |-> convEnd)
    else $error("low power entered outside conversion end");
  a_wake_min_time: assert property ($rose(converterReady) |-> lowCnt_q >= WAKE_MIN)
    else $error("recovery interval too short");
  a_ready_active: assert property ((powerState == adc_setup_pkg::PWR_ACTIVE) [*2] |->
    converterReady)
    else $error("ready low while powered");
  a_hold_starts: assert property (convStart |-> ##[1:4] sampleHold)
    else $error("conversion did not start");
endmodule // adc_setup_monitor

bind adc_setup_core adc_setup_monitor #(.DOWN_WAKE_CYCLES(DOWN_WAKE_CYCLES)) mon (
  .mclk(mclk), .reset(reset), .serialClock(serialClock), .serial_in_line(serial_in_line),
  .convert_strobe(convert_strobe), .sampleData(sampleData), .serial_out_line(serial_out_line),
  .channel_select(channel_select), .powerState(powerState), .converterReady(converterReady),
  .sampleHold(sampleHold));

//--- verification/spi_host_model.sv
// host model driving the serial link and the convert strobe
`timescale 1ns/1ps
module spi_host_model (
  input wire logic mclk,
  input wire logic sdoLine,
  output logic serialClock,
  output logic serialIn,
  output logic strobe
);
  // serial clock stands low outside frames and the reset pulses; frames run only while strobe is low
  initial begin
    serialClock = 1'b0;
    serialIn = 1'b0;
    strobe = 1'b1;
  end

  task automatic pulse(input int n);
    repeat (n) begin
      #15 serialClock = 1'b1;
      #15 serialClock = 1'b0;
    end
  endtask

  task automatic acquire();
    @(negedge mclk);
    strobe <= 1'b0;
  endtask

  // frame ends before the strobe rises, so never near conversion end
  task automatic convert();
    #400;
    @(negedge mclk);
    strobe <= 1'b1;
    #4000;
  endtask

  // 29 rises: first 16 load the word, rises 2..29 collect 28 bits
  task automatic frame(input logic [15:0] w, output logic [27:0] rx);
    #7;
    for (int i = 0; i < 29; i++) begin
      serialIn = (i < 16) ? w[15-i] : 1'b0;
      #15 serialClock = 1'b1;
      if (i > 0) rx[28-i] = sdoLine;
      #15 serialClock = 1'b0;
    end
  endtask
endmodule // spi_host_model

//--- verification/adc_config_register_readback_test.sv
// self-checking bench for the converter setup core
`timescale 1ns/1ps
module adc_config_register_readback_test;
  logic mclk;
  logic reset;
  logic serialClock;
  logic serialIn;
  logic strobe;
  logic sdoLine;
  logic [11:0] sampleData;
  adc_setup_pkg::line_pin_s pin;
  logic [2:0] channel_select;
  adc_setup_pkg::power_state_e powerState;
  logic converterReady;
  logic sampleHold;
  int err_total;
  int n_compared;
  logic [15:0] act;
  logic [15:0] prevSetup;
  logic [11:0] prevData;
  logic prevRb;
  logic havePrev;

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  // a released line shows the inverse of its last value
  assign sdoLine = pin.oeN ? ~pin.out : pin.out;

  adc_setup_core #(.DOWN_WAKE_CYCLES(20)) dut (
    .mclk(mclk), .reset(reset), .serialClock(serialClock), .serial_in_line(serialIn),
    .convert_strobe(strobe), .sampleData(sampleData), .serial_out_line(pin),
    .channel_select(channel_select), .powerState(powerState),
    .converterReady(converterReady), .sampleHold(sampleHold));
  spi_host_model host (.mclk(mclk), .sdoLine(sdoLine), .serialClock(serialClock),
    .serialIn(serialIn), .strobe(strobe));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic good, input string what);
    n_compared++;
    if (good !== 1'b1) begin
      err_total++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask

  task automatic complete_run();
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic adc_setup_pkg::power_state_e expPower(input logic [1:0] p);
    if (p[1]) return adc_setup_pkg::PWR_SLEEP;
    if (p[0]) return adc_setup_pkg::PWR_ACTIVE;
    return adc_setup_pkg::PWR_DOWN;
  endfunction

  // one acquire, frame and conversion; reads the previous snapshot
  task automatic run_cycle(input logic [15:0] w, input logic [11:0] d);
    logic [27:0] rx;
    host.acquire();
    #100;
    check(converterReady === (act[10:9] == 2'h1), "ready after strobe fall");
    check(sdoLine === 1'b1, "output level before first clock");
    host.frame(w, rx);
    if (havePrev) check(rx === {prevData, prevRb ? prevSetup : 16'h0}, "stream");
    @(negedge mclk);
    sampleData = d;
    host.convert();
    prevSetup = act;
    prevRb = act[7];
    prevData = d;
    havePrev = 1'b1;
    if (w[15:14] == adc_setup_pkg::LOAD_KEY_ACCEPT) act = w & 16'h3e80;
    @(negedge mclk);
    check(channel_select === act[13:11], "channel");
    check(powerState === expPower(act[10:9]), "power state");
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic check_reset();
    check(pin.oeN === 1'b1 && pin.out === 1'b1, "pin after reset");
    check(channel_select === 3'h0 && converterReady === 1'b1, "channel after reset");
    check(powerState === adc_setup_pkg::PWR_ACTIVE && sampleHold === 1'b0, "power after reset");
  endtask

  // channel codes one to seven and every power code, junk in unused bits first
  task automatic accept_words();
    logic [15:0] words [7];
    words = '{16'hcbff, 16'hf880, 16'he480, 16'hd600, 16'hda80, 16'hea00, 16'hf280};
    foreach (words[i]) run_cycle(words[i], 12'(i * 12'h2b7) ^ 12'h9c3);
  endtask

  task automatic refuse_keys();
    run_cycle(16'hbfff, 12'hfff);
    run_cycle(16'h7fff, 12'h001);
    run_cycle(16'h0000, 12'h800);
  endtask

  initial begin
    reset = 1'b1;
    sampleData = 12'h0;
    err_total = 0;
    n_compared = 0;
    act = {2'h0, adc_setup_pkg::CHANNEL_RESET, adc_setup_pkg::POLICY_RESET, 1'b0,
      adc_setup_pkg::READBACK_RESET, 7'h0};
    havePrev = 1'b0;
    // link side reset needs serial edges as well
    host.pulse(4);
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    // the link reset lags by two serial rises after release
    host.pulse(2);
    repeat (3) @(negedge mclk);
    check_reset();
    accept_words();
    refuse_keys();
    complete_run();
  end

  initial begin
    #150000;
    err_total++;
    complete_run();
  end
endmodule // adc_config_register_readback_test
